// File: logic/apc_params.svh
`ifndef APC_PARAMS_SVH
`define APC_PARAMS_SVH

// Byte offset of the auxiliary pipeline control register on the bus.
`define APC_AUX_CTRL_OFFSET  32'h0000_0000
// Reset value: every optimisation enabled, reserved bits zero.
`define APC_AUX_CTRL_RESET   32'h0000_0000
// Field positions.
`define APC_RSVD_HI          31
`define APC_RSVD_LO          29
`define APC_FLOAT_OPT_BIT    28
`define APC_CRIT_HOLD_BIT    27
`define APC_ADDSUB_OFF_BIT   26
`define APC_SCH_BLOCK_HI     25
`define APC_SCH_BLOCK_LO     21
`define APC_DI_BLOCK_HI      20
`define APC_DI_BLOCK_LO      16
// Number of instruction types per block field.
`define APC_NUM_TYPES        5

`endif

// File: logic/apc_pkg.sv
`default_nettype none
package apc_pkg;

  // Instruction type mask, one bit per type in field order.
  // Bit 4 float, 3 multiply/MAC, 2 loads to PC, 1 indirect branch, 0 direct branch.
  typedef logic [4:0] apc_type_mask_t;

  // Decoded controls handed to the issue logic, execute stages and AXI master.
  typedef struct packed {
    logic           float_issue_optimisation_off;
    logic           critical_read_hold;
    logic           dynamic_addsub_off;
    apc_type_mask_t second_channel_issue_block;
    apc_type_mask_t dual_issue_block;
  } apc_ctrl_t;

  // Bus slave data phase states.
  typedef enum logic [0:0] {
    APC_IDLE  = 1'b0,
    APC_WDATA = 1'b1
  } apc_phase_t;

endpackage
`default_nettype wire

// File: logic/apc_aux_pipeline_control.sv
// Contract
// - Register always present, accessible at any time.
// - Hold bit clear keeps normal read ordering.
// - Hold bit set delays ordered reads behind stores.
// - Addsub bit clear allows first-stage resolve.
// - Addsub bit set forces second-stage resolve.
// - Bits 25:21 block types from channel one.
// - Channel-one bits map float, mul, ldpc, ind, direct.
// - Bits 20:16 block dual issue per type.
// - Dual-issue bits map float, mul, ldpc, ind, direct.
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "apc_params.svh"

module apc_aux_pipeline_control (
  // Clock and reset.
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave.
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic [31:0]            hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Controls to the core.
  output apc_pkg::apc_ctrl_t     ctrl
);

  logic [31:0]         ctrl_reg;
  logic [31:0]         ctrl_next;
  apc_pkg::apc_phase_t phase_reg;
  logic                hit_reg;

  // Decode: an address that falls in the control word; validity comes from take.
  function automatic logic addr_hit(input logic [31:0] a);
    addr_hit = (a[31:2] == 30'(`APC_AUX_CTRL_OFFSET >> 2));
  endfunction

  logic take;
  assign take = hsel & hready & htrans[1];

  // Writable image: reserved bits forced to zero.
  always_comb begin
    ctrl_next = ctrl_reg;
    if (phase_reg == apc_pkg::APC_WDATA && hit_reg) begin
      ctrl_next = hwdata;
      ctrl_next[`APC_RSVD_HI:`APC_RSVD_LO] = 3'h0;
    end
  end

  // Address phase capture; the slave never inserts wait states.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_reg <= apc_pkg::APC_IDLE;
      hit_reg   <= 1'h0;
    end else begin
      phase_reg <= (take && hwrite) ? apc_pkg::APC_WDATA : apc_pkg::APC_IDLE;
      hit_reg   <= take && addr_hit(haddr);
    end
  end

  // Register store, writable at any time.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `APC_AUX_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // Read data loaded in the address phase; unmapped words read zero.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (take && !hwrite) begin
      hrdata <= addr_hit(haddr) ? ctrl_next : 32'h0000_0000;
    end
  end

  // Ready and OKAY from the first edge after reset; not ready during reset.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'h0;
      hresp     <= 1'h0;
    end else begin
      hreadyout <= 1'h1;
      hresp     <= 1'h0;
    end
  end

  // Field outputs, registered from the next-state image so they track the register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= '0;
    end else begin
      ctrl.float_issue_optimisation_off <= ctrl_next[`APC_FLOAT_OPT_BIT];
      ctrl.critical_read_hold           <= ctrl_next[`APC_CRIT_HOLD_BIT];
      ctrl.dynamic_addsub_off           <= ctrl_next[`APC_ADDSUB_OFF_BIT];
      ctrl.second_channel_issue_block   <= ctrl_next[`APC_SCH_BLOCK_HI:`APC_SCH_BLOCK_LO];
      ctrl.dual_issue_block             <= ctrl_next[`APC_DI_BLOCK_HI:`APC_DI_BLOCK_LO];
    end
  end

  // The reserved top bits of the register never hold a one.
  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
      ctrl_reg[31:29] == 3'h0;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

  // An accepted write address phase followed by its data phase.
  sequence s_write(hit);
    take && hwrite && hit ##1 1'b1;
  endsequence

  // The read hold control takes the written bit one edge after the data phase.
  property p_hold_follows_write;
    @(posedge hclk) disable iff (!hresetn)
      s_write(addr_hit(haddr)) |=> ctrl.critical_read_hold == $past(hwdata[27]);
  endproperty
  a_hold_follows_write: assert property (p_hold_follows_write) else $error("hold bit wrong");

  // The add/subtract control takes the written bit one edge after the data phase.
  property p_addsub_follows_write;
    @(posedge hclk) disable iff (!hresetn)
      s_write(addr_hit(haddr)) |=> ctrl.dynamic_addsub_off == $past(hwdata[26]);
  endproperty
  a_addsub_follows_write: assert property (p_addsub_follows_write) else $error("addsub bit wrong");

  // The channel one block field always mirrors its register bits.
  property p_sch_matches;
    @(posedge hclk) disable iff (!hresetn)
      ctrl.second_channel_issue_block == ctrl_reg[25:21];
  endproperty
  a_sch_matches: assert property (p_sch_matches) else $error("channel block mismatch");

  // The dual issue block field always mirrors its register bits.
  property p_di_matches;
    @(posedge hclk) disable iff (!hresetn)
      ctrl.dual_issue_block == ctrl_reg[20:16];
  endproperty
  a_di_matches: assert property (p_di_matches) else $error("dual issue mismatch");

  // The read hold control always mirrors its register bit.
  property p_hold_matches;
    @(posedge hclk) disable iff (!hresetn)
      ctrl.critical_read_hold == ctrl_reg[27];
  endproperty
  a_hold_matches: assert property (p_hold_matches) else $error("hold mismatch");

  // The add/subtract control always mirrors its register bit.
  property p_addsub_matches;
    @(posedge hclk) disable iff (!hresetn)
      ctrl.dynamic_addsub_off == ctrl_reg[26];
  endproperty
  a_addsub_matches: assert property (p_addsub_matches) else $error("addsub mismatch");

  // A read of the control word returns the register in its data phase.
  property p_read_back;
    @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && addr_hit(haddr)) |=> hrdata == ctrl_reg && hresp == 1'b0;
  endproperty
  a_read_back: assert property (p_read_back) else $error("read data wrong");

  // Once out of reset for a full cycle the slave is always ready and answers OKAY.
  property p_ready_after_reset;
    @(posedge hclk) disable iff (!hresetn)
      $past(hresetn) && hresetn |-> hreadyout == 1'h1 && hresp == 1'h0;
  endproperty
  a_ready_after_reset: assert property (p_ready_after_reset) else $error("slave not ready");

  // A write to the control word stores every writable bit and clears the reserved ones.
  property p_write_lands;
    @(posedge hclk) disable iff (!hresetn)
      s_write(addr_hit(haddr)) |=> ctrl_reg == {3'h0, $past(hwdata[28:0])};
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("write not stored");

  // Without a write data phase to the control word the register keeps its value.
  property p_idle_keeps;
    @(posedge hclk) disable iff (!hresetn)
      !(phase_reg == apc_pkg::APC_WDATA && hit_reg) |=> $stable(ctrl_reg);
  endproperty
  a_idle_keeps: assert property (p_idle_keeps) else $error("register changed without write");

  // A read of any other word returns zero.
  property p_unmapped_read_zero;
    @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && !addr_hit(haddr)) |=> hrdata == 32'h0000_0000;
  endproperty
  a_unmapped_read_zero: assert property (p_unmapped_read_zero) else $error("unmapped read nonzero");

  // Read data stands until the next accepted read.
  property p_hrdata_stands;
    @(posedge hclk) disable iff (!hresetn)
      !(take && !hwrite) |=> $stable(hrdata);
  endproperty
  a_hrdata_stands: assert property (p_hrdata_stands) else $error("read data changed");

  // The float issue control always mirrors its register bit.
  property p_float_matches;
    @(posedge hclk) disable iff (!hresetn)
      ctrl.float_issue_optimisation_off == ctrl_reg[28];
  endproperty
  a_float_matches: assert property (p_float_matches) else $error("float issue mismatch");

  // Each instruction type keeps its own bit in both block fields.
  for (genvar g = 0; g < `APC_NUM_TYPES; g++) begin : g_type
    property p_sch_type;
      @(posedge hclk) disable iff (!hresetn)
        ctrl.second_channel_issue_block[g] == ctrl_reg[`APC_SCH_BLOCK_LO + g];
    endproperty
    a_sch_type: assert property (p_sch_type) else $error("channel block type mismatch");

    property p_di_type;
      @(posedge hclk) disable iff (!hresetn)
        ctrl.dual_issue_block[g] == ctrl_reg[`APC_DI_BLOCK_LO + g];
    endproperty
    a_di_type: assert property (p_di_type) else $error("dual issue type mismatch");
  end

endmodule
`default_nettype wire

// File: verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic               hclk;
  logic               hresetn;
  logic               hsel;
  logic [31:0]        haddr;
  logic [1:0]         htrans;
  logic               hwrite;
  logic [2:0]         hsize;
  logic [31:0]        hwdata;
  logic [31:0]        hrdata;
  logic               hreadyout;
  logic               hresp;
  apc_pkg::apc_ctrl_t ctrl;
  logic [31:0]        rd;
  int                 bad_count;
  int                 comparisons;

  apc_aux_pipeline_control apc_aux_pipeline_control_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ctrl(ctrl));

  // Bus clock, 25 ns period.
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // Prints the counts and the verdict.
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Compares one word.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits, bounded, for ready sampled high at a rising edge.
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      bad_count++;
      summarize();
    end
  endtask

  // One single-word transfer; read data taken at the data phase edge.
  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    hsize  <= 3'h2;
    htrans <= 2'b10;
    wait_ready();
    htrans <= 2'b00;
    hwdata <= d;
    wait_ready();
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Reset value, reserved bits and a reset in mid-run.
  task automatic t_reset;
    xfer(32'h0, 1'b0, 32'h0, rd);
    chk("reset read", 32'h0, rd);
    chk("reset ctrl", 32'h0, {19'h0, ctrl});
    xfer(32'h0, 1'b1, 32'hffff_ffff, rd);
    xfer(32'h0, 1'b0, 32'h0, rd);
    chk("all ones", 32'h1fff_ffff, rd);
    @(posedge hclk);
    hresetn <= 1'b0;
    @(negedge hclk);
    chk("ctrl in reset", 32'h0, {19'h0, ctrl});
    @(posedge hclk);
    hresetn <= 1'b1;
    xfer(32'h0, 1'b0, 32'h0, rd);
    chk("read after reset", 32'h0, rd);
    $display("test reset done");
  endtask

  // Each control bit alone drives its own output and reads back.
  task automatic t_fields;
    for (int i = 0; i < 13; i++) begin
      xfer(32'h0, 1'b1, 32'h1 << (16 + i), rd);
      @(negedge hclk);
      chk("ctrl bit", 32'h1 << i, {19'h0, ctrl});
      xfer(32'h0, 1'b0, 32'h0, rd);
      chk("readback", 32'h1 << (16 + i), rd);
    end
    $display("test fields done");
  endtask

  // Unmapped address reads zero and ignores writes.
  task automatic t_unmapped;
    xfer(32'h0, 1'b1, 32'h0155_a5a5, rd);
    xfer(32'h4, 1'b1, 32'hffff_ffff, rd);
    xfer(32'h4, 1'b0, 32'h0, rd);
    chk("unmapped read", 32'h0, rd);
    xfer(32'h0, 1'b0, 32'h0, rd);
    chk("kept value", 32'h0155_a5a5, rd);
    chk("kept ctrl", 32'h155, {19'h0, ctrl});
    $display("test unmapped done");
  endtask

  // Main sequence.
  initial begin
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hsize       = 3'h2;
    hwdata      = 32'h0;
    bad_count   = 0;
    comparisons = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_fields();
    t_unmapped();
    summarize();
  end
endmodule
`default_nettype wire
